/* File: verilog/fpt_pkg.sv */
// constants, types and symbol coding shared by the transmit path
// How it works
// - each parallel byte is 10 bits: parity, control flag, two 4-bit symbols
// - every byte taken must carry odd parity over all ten bits
// - transmit state bit 6 switches the parity check on or off
// - a parity error sets interrupt condition bit 0 and feeds the filter
// - data nibbles map to their fixed 5-bit codes, 0 to 11110, F to 11101
// - JK becomes 11000 10001, T 01101, Reset 00111, Set 11001
// - violations inside a frame become two Halt pairs then Idle pairs
// - the smoother aims at 7 preamble Idle pairs, deleting a held Idle pair beyond 7 only while an inserted pair is held
// - a preamble of 1 to 6 Idle pairs gets one extra Idle pair inserted unless an inserted pair is still held
// - preamble counting starts on an Idle pair and stops on a JK pair
// - transmit mode bits 2:0 pick the line state that overrides the stream
// - active passes, off quiets and disables optics, others send their pairs
// - a reserved transmit mode sends Quiet pairs
// - injected pairs win over line state, filter and smoother outputs
// - injection mode picks none, one-shot, periodic or continuous
// - one-shot injects once on the nth byte after a JK
// - periodic injects repeatedly every (n+1)th position
// - continuous replaces every pair, same as periodic with n of 0
// - the injection threshold goes up to 255
// - pairs load into the shift register per byte, shift out per bit
// - mode bit 6 low sends NRZI, high sends plain NRZ
// - serial output goes to the optics, or to clock recovery in loopback
package fpt_pkg;
	// serializer framing: one pair is ten line bits
	localparam logic [3:0] BIT_LAST = 4'h9;
	// 5-bit line symbols
	localparam logic [4:0] SYM_I = 5'h1F;
	localparam logic [4:0] SYM_H = 5'h04;
	localparam logic [4:0] SYM_Q = 5'h00;
	localparam logic [4:0] SYM_J = 5'h18;
	localparam logic [4:0] SYM_K = 5'h11;
	localparam logic [4:0] SYM_T = 5'h0D;
	localparam logic [4:0] SYM_R = 5'h07;
	localparam logic [4:0] SYM_S = 5'h19;
	localparam logic [4:0] SYM_V = 5'h01;
	// nibble values carried by control bytes
	localparam logic [3:0] CN_IDLE = 4'h0;
	localparam logic [3:0] CN_HALT = 4'h1;
	localparam logic [3:0] CN_QUIET = 4'h2;
	localparam logic [3:0] CN_T0 = 4'h4;
	localparam logic [3:0] CN_T1 = 4'h5;
	localparam logic [3:0] CN_R = 4'h6;
	localparam logic [3:0] CN_S = 4'h7;
	localparam logic [3:0] CN_JK = 4'hD;
	// register byte offsets
	localparam logic [7:0] ADDR_TSR = 8'h00;
	localparam logic [7:0] ADDR_ICR = 8'h04;
	localparam logic [7:0] ADDR_INJ = 8'h08;
	localparam logic [7:0] ADDR_ISA = 8'h0C;
	localparam logic [7:0] ADDR_ISB = 8'h10;
	localparam logic [7:0] ADDR_THR = 8'h14;
	localparam logic [7:0] ADDR_MR = 8'h18;
	localparam logic [7:0] ADDR_STAT = 8'h1C;
	// field positions and masks
	localparam int TSR_PAREN_BIT = 6;
	localparam int ICR_PARERR_BIT = 0;
	localparam int MR_LOOP_BIT = 1;
	localparam int MR_NRZ_BIT = 6;
	localparam logic [7:0] TSR_MASK = 8'h47;
	localparam logic [7:0] MR_MASK = 8'h42;
	// reset values: transmitter off, everything else cleared
	localparam logic [7:0] TSR_RST = 8'h05;
	localparam logic [7:0] MR_RST = 8'h00;
	localparam logic [3:0] SMOOTH_TARGET = 4'h7;
	localparam logic [3:0] IDLE_CNT_MAX = 4'hF;

	typedef enum logic [2:0] {
		TM_ACTIVE = 3'h0,
		TM_IDLE = 3'h1,
		TM_MASTER = 3'h2,
		TM_QUIET = 3'h3,
		TM_HALT = 3'h4,
		TM_OFF = 3'h5,
		TM_RSVD6 = 3'h6,
		TM_RSVD7 = 3'h7
	} fpt_tmode_t;

	typedef enum logic [1:0] {
		INJ_NONE = 2'h0,
		INJ_ONESHOT = 2'h1,
		INJ_PERIODIC = 2'h2,
		INJ_CONT = 2'h3
	} fpt_inj_t;

	typedef enum logic [1:0] {
		RF_PASS = 2'h0,
		RF_HALT = 2'h1,
		RF_IDLE = 2'h2
	} fpt_rf_t;

	// parallel byte from the configuration switch
	typedef struct packed {
		logic parity;
		logic ctrl;
		logic [7:0] data;
	} fpt_txbyte_t;

	// one symbol pair in line code, first symbol goes out first
	typedef struct packed {
		logic [4:0] first;
		logic [4:0] second;
	} fpt_pair_t;

	localparam fpt_pair_t PAIR_II = '{first: SYM_I, second: SYM_I};
	localparam fpt_pair_t PAIR_HH = '{first: SYM_H, second: SYM_H};
	localparam fpt_pair_t PAIR_QQ = '{first: SYM_Q, second: SYM_Q};
	localparam fpt_pair_t PAIR_HQ = '{first: SYM_H, second: SYM_Q};
	localparam fpt_pair_t PAIR_JK = '{first: SYM_J, second: SYM_K};

	// data nibble to 5-bit code
	function automatic logic [4:0] enc_data(input logic [3:0] n);
		unique case (n)
			4'h0: enc_data = 5'h1E;
			4'h1: enc_data = 5'h09;
			4'h2: enc_data = 5'h14;
			4'h3: enc_data = 5'h15;
			4'h4: enc_data = 5'h0A;
			4'h5: enc_data = 5'h0B;
			4'h6: enc_data = 5'h0E;
			4'h7: enc_data = 5'h0F;
			4'h8: enc_data = 5'h12;
			4'h9: enc_data = 5'h13;
			4'hA: enc_data = 5'h16;
			4'hB: enc_data = 5'h17;
			4'hC: enc_data = 5'h1A;
			4'hD: enc_data = 5'h1B;
			4'hE: enc_data = 5'h1C;
			4'hF: enc_data = 5'h1D;
		endcase
	endfunction : enc_data

	// control nibble to 5-bit code; unknown values become violations
	function automatic logic [4:0] enc_ctrl(input logic [3:0] n);
		case (n)
			CN_IDLE: enc_ctrl = SYM_I;
			CN_HALT: enc_ctrl = SYM_H;
			CN_QUIET: enc_ctrl = SYM_Q;
			CN_T0, CN_T1: enc_ctrl = SYM_T;
			CN_R: enc_ctrl = SYM_R;
			CN_S: enc_ctrl = SYM_S;
			default: enc_ctrl = SYM_V;
		endcase
	endfunction : enc_ctrl

	// whole byte to symbol pair
	function automatic fpt_pair_t encode_byte(input fpt_txbyte_t b);
		if (!b.ctrl) begin
			encode_byte = {enc_data(b.data[7:4]), enc_data(b.data[3:0])};
		end else if (b.data[7:4] == CN_JK) begin
			encode_byte = PAIR_JK;
		end else begin
			encode_byte = {enc_ctrl(b.data[7:4]), enc_ctrl(b.data[3:0])};
		end
	endfunction : encode_byte

	function automatic logic is_idle(input fpt_pair_t p);
		is_idle = (p == PAIR_II);
	endfunction : is_idle

	function automatic logic is_jk(input fpt_pair_t p);
		is_jk = (p == PAIR_JK);
	endfunction : is_jk
endpackage : fpt_pkg

/* File: verilog/fpt_serializer.sv */
// shift register and NRZI coder that put symbol pairs onto the line
`timescale 1ns/10ps
module fpt_serializer (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// parallel side
	input wire logic [9:0] pairCode,
	input wire logic nrzSelect,
	output logic slotReq,
	// serial side
	output logic serialOut
);
	logic [3:0] bitCnt;
	logic [3:0] next_bitCnt;
	logic [9:0] shiftReg;
	logic [9:0] next_shiftReg;
	logic next_serialOut;

	// a new pair is asked for in the last bit time of the current one
	assign slotReq = (bitCnt == fpt_pkg::BIT_LAST);

	// load once per byte time, otherwise shift msb first
	always_comb begin
		next_bitCnt = bitCnt + 4'h1;
		next_shiftReg = {shiftReg[8:0], 1'b0};
		if (slotReq) begin
			next_bitCnt = 4'h0;
			next_shiftReg = pairCode;
		end
		if (nrzSelect) begin
			next_serialOut = shiftReg[9];
		end else begin
			next_serialOut = serialOut ^ shiftReg[9];
		end
	end

	// state freezes while ce is low
	always_ff @(posedge clk) begin
		if (rst) begin
			bitCnt <= 4'h0;
			shiftReg <= 10'h000;
			serialOut <= 1'b0;
		end else if (ce) begin
			bitCnt <= next_bitCnt;
			shiftReg <= next_shiftReg;
			serialOut <= next_serialOut;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst || !ce);

	nrzi_toggle_a: assert property (!nrzSelect |=>
		serialOut == ($past(serialOut) ^ $past(shiftReg[9])))
		else $error("nrzi output did not follow the bit");
	nrz_pass_a: assert property (nrzSelect |=>
		serialOut == $past(shiftReg[9]))
		else $error("nrz output differs from the shifted bit");
	slot_period_a: assert property (slotReq |=>
		!slotReq [*8] ##1 !slotReq ##1 slotReq)
		else $error("byte slot period is not ten bits");
endmodule : fpt_serializer

/* File: verilog/fpt_transmit.sv */
// transmit path: bus registers, encoder, filter, smoother, line state, inject
//
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module fpt_transmit (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// parallel bytes from the configuration switch
	input wire fpt_pkg::fpt_txbyte_t txByte,
	input wire logic txByteValid,
	output logic txByteReady,
	// serial line
	output logic opticSerial,
	output logic opticEnable,
	output logic loopSerial
);
	// register state
	logic [7:0] transmit_state_reg;
	logic [7:0] interrupt_condition_reg;
	logic [1:0] injection_mode_select;
	logic [4:0] injection_symbol_first;
	logic [4:0] injection_symbol_second;
	logic [7:0] injection_threshold;
	logic [7:0] mode_reg;
	logic dpValid, dpWrite;
	logic [7:0] dpAddr;
	logic [7:0] next_tsr, next_icr, next_thr, next_mr;
	logic [7:0] next_dpAddr, icrClear;
	logic [1:0] next_injMode;
	logic [4:0] next_isA, next_isB;
	logic next_dpValid, next_dpWrite, addrPhase;
	logic [31:0] next_hrdata;

	// datapath state
	fpt_pkg::fpt_rf_t rfState, next_rfState;
	logic inFrame, next_inFrame, holdValid, next_holdValid;
	fpt_pkg::fpt_pair_t hold, next_hold, txCode, next_txCode;
	logic [3:0] idleCnt, next_idleCnt;
	logic oneArmed, next_oneArmed;
	logic [7:0] oneOfs, next_oneOfs, perCnt, next_perCnt;
	logic next_opticSerial, next_opticEnable, next_loopSerial;

	// combinational stream terms
	fpt_pkg::fpt_tmode_t tmode;
	fpt_pkg::fpt_inj_t injMode;
	fpt_pkg::fpt_pair_t inPair;
	fpt_pkg::fpt_pair_t filtPair;
	fpt_pkg::fpt_pair_t smoothPair;
	fpt_pkg::fpt_pair_t lsgPair;
	fpt_pkg::fpt_pair_t injPair;
	logic parErr;
	logic viol;
	logic injHit;
	logic slotReq;
	logic serialRaw;
	logic parEn;
	logic loopback;

	assign tmode = fpt_pkg::fpt_tmode_t'(transmit_state_reg[2:0]);
	assign injMode = fpt_pkg::fpt_inj_t'(injection_mode_select);
	assign parEn = transmit_state_reg[fpt_pkg::TSR_PAREN_BIT];
	assign loopback = mode_reg[fpt_pkg::MR_LOOP_BIT];
	assign injPair = {injection_symbol_first, injection_symbol_second};

	// zero-wait slave: always ready, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addrPhase = hsel && hready && htrans[1];
	// one byte is taken per byte slot, so the source is paced by the line
	assign txByteReady = slotReq;

	// bus registers: address phase captured, write applied in data phase
	always_comb begin
		next_tsr = transmit_state_reg;
		next_injMode = injection_mode_select;
		next_isA = injection_symbol_first;
		next_isB = injection_symbol_second;
		next_thr = injection_threshold;
		next_mr = mode_reg;
		icrClear = 8'h00;
		next_dpValid = addrPhase;
		next_dpWrite = hwrite;
		next_dpAddr = haddr[7:0];
		next_hrdata = hrdata;
		if (dpValid && dpWrite) begin
			case (dpAddr)
				fpt_pkg::ADDR_TSR: next_tsr = hwdata[7:0] & fpt_pkg::TSR_MASK;
				fpt_pkg::ADDR_ICR: icrClear = hwdata[7:0];
				fpt_pkg::ADDR_INJ: next_injMode = hwdata[1:0];
				fpt_pkg::ADDR_ISA: next_isA = hwdata[4:0];
				fpt_pkg::ADDR_ISB: next_isB = hwdata[4:0];
				fpt_pkg::ADDR_THR: next_thr = hwdata[7:0];
				fpt_pkg::ADDR_MR: next_mr = hwdata[7:0] & fpt_pkg::MR_MASK;
				default: ;
			endcase
		end
		// write-one-to-clear, but a new error in the same cycle stays set
		next_icr = interrupt_condition_reg & ~icrClear;
		if (parErr) begin
			next_icr[fpt_pkg::ICR_PARERR_BIT] = 1'b1;
		end
		if (addrPhase && !hwrite) begin
			case (haddr[7:0])
				fpt_pkg::ADDR_TSR: next_hrdata = {24'h000000, transmit_state_reg};
				fpt_pkg::ADDR_ICR:
					next_hrdata = {24'h000000, interrupt_condition_reg};
				fpt_pkg::ADDR_INJ:
					next_hrdata = {30'h0000000, injection_mode_select};
				fpt_pkg::ADDR_ISA:
					next_hrdata = {27'h000000, injection_symbol_first};
				fpt_pkg::ADDR_ISB:
					next_hrdata = {27'h000000, injection_symbol_second};
				fpt_pkg::ADDR_THR: next_hrdata = {24'h000000, injection_threshold};
				fpt_pkg::ADDR_MR: next_hrdata = {24'h000000, mode_reg};
				fpt_pkg::ADDR_STAT:
					next_hrdata = {24'h000000, inFrame, holdValid, rfState, idleCnt};
				default: next_hrdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			transmit_state_reg <= fpt_pkg::TSR_RST;
			interrupt_condition_reg <= 8'h00;
			injection_mode_select <= 2'h0;
			injection_symbol_first <= 5'h00;
			injection_symbol_second <= 5'h00;
			injection_threshold <= 8'h00;
			mode_reg <= fpt_pkg::MR_RST;
			dpValid <= 1'b0;
			dpWrite <= 1'b0;
			dpAddr <= 8'h00;
			hrdata <= 32'h00000000;
		end else if (ce) begin
			transmit_state_reg <= next_tsr;
			interrupt_condition_reg <= next_icr;
			injection_mode_select <= next_injMode;
			injection_symbol_first <= next_isA;
			injection_symbol_second <= next_isB;
			injection_threshold <= next_thr;
			mode_reg <= next_mr;
			dpValid <= next_dpValid;
			dpWrite <= next_dpWrite;
			dpAddr <= next_dpAddr;
			hrdata <= next_hrdata;
		end
	end

	// the whole stream advances once per byte slot
	always_comb begin
		// a missing byte is sent as an Idle pair so the line never starves
		inPair = txByteValid ? fpt_pkg::encode_byte(txByte) : fpt_pkg::PAIR_II;
		parErr = slotReq && txByteValid && parEn && !(^txByte);
		viol = parErr || inPair.first == fpt_pkg::SYM_V
			|| inPair.second == fpt_pkg::SYM_V;
		next_rfState = rfState;
		next_inFrame = inFrame;
		filtPair = inPair;
		// repeat filter
		unique case (rfState)
			fpt_pkg::RF_PASS: begin
				if (inFrame && viol) begin
					filtPair = fpt_pkg::PAIR_HH;
					next_rfState = fpt_pkg::RF_HALT;
					next_inFrame = 1'b0;
				end else if (fpt_pkg::is_jk(inPair)) begin
					next_inFrame = 1'b1;
				end else if (inPair.first == fpt_pkg::SYM_T
					|| inPair.second == fpt_pkg::SYM_T
					|| fpt_pkg::is_idle(inPair)
					|| inPair.first == fpt_pkg::SYM_H
					|| inPair.first == fpt_pkg::SYM_Q) begin
					next_inFrame = 1'b0;
				end
			end
			fpt_pkg::RF_HALT: begin
				filtPair = fpt_pkg::PAIR_HH;
				next_rfState = fpt_pkg::RF_IDLE;
			end
			fpt_pkg::RF_IDLE: begin
				if (fpt_pkg::is_jk(inPair)) begin
					next_rfState = fpt_pkg::RF_PASS;
					next_inFrame = 1'b1;
				end else begin
					filtPair = fpt_pkg::PAIR_II;
				end
			end
			default: begin
				filtPair = fpt_pkg::PAIR_II;
				next_rfState = fpt_pkg::RF_IDLE;
			end
		endcase
		// smoother: a one-pair hold gives room to extend or shrink preambles
		next_hold = hold;
		next_holdValid = holdValid;
		smoothPair = filtPair;
		if (holdValid) begin
			if (fpt_pkg::is_idle(hold) && idleCnt >= fpt_pkg::SMOOTH_TARGET) begin
				next_holdValid = 1'b0;
			end else begin
				smoothPair = hold;
				next_hold = filtPair;
			end
		end else if (fpt_pkg::is_jk(filtPair) && idleCnt != 4'h0
			&& idleCnt < fpt_pkg::SMOOTH_TARGET) begin
			smoothPair = fpt_pkg::PAIR_II;
			next_hold = filtPair;
			next_holdValid = 1'b1;
		end
		next_idleCnt = idleCnt;
		if (fpt_pkg::is_jk(smoothPair)) begin
			next_idleCnt = 4'h0;
		end else if (fpt_pkg::is_idle(smoothPair)
			&& idleCnt != fpt_pkg::IDLE_CNT_MAX) begin
			next_idleCnt = idleCnt + 4'h1;
		end
		// line state generator
		unique case (tmode)
			fpt_pkg::TM_ACTIVE: lsgPair = smoothPair;
			fpt_pkg::TM_IDLE: lsgPair = fpt_pkg::PAIR_II;
			fpt_pkg::TM_MASTER: lsgPair = fpt_pkg::PAIR_HQ;
			fpt_pkg::TM_HALT: lsgPair = fpt_pkg::PAIR_HH;
			fpt_pkg::TM_QUIET, fpt_pkg::TM_OFF: lsgPair = fpt_pkg::PAIR_QQ;
			fpt_pkg::TM_RSVD6, fpt_pkg::TM_RSVD7: lsgPair = fpt_pkg::PAIR_QQ;
		endcase
		// injection control
		injHit = 1'b0;
		next_oneArmed = oneArmed;
		next_oneOfs = oneOfs;
		next_perCnt = perCnt;
		unique case (injMode)
			fpt_pkg::INJ_NONE: ;
			fpt_pkg::INJ_ONESHOT: begin
				if (fpt_pkg::is_jk(smoothPair)) begin
					injHit = (injection_threshold == 8'h00);
					next_oneArmed = (injection_threshold != 8'h00);
					next_oneOfs = 8'h01;
				end else if (oneArmed) begin
					if (oneOfs == injection_threshold) begin
						injHit = 1'b1;
						next_oneArmed = 1'b0;
					end else begin
						next_oneOfs = oneOfs + 8'h01;
					end
				end
			end
			fpt_pkg::INJ_PERIODIC: begin
				if (perCnt == injection_threshold) begin
					injHit = 1'b1;
					next_perCnt = 8'h00;
				end else begin
					next_perCnt = perCnt + 8'h01;
				end
			end
			fpt_pkg::INJ_CONT: injHit = 1'b1;
		endcase
		next_txCode = injHit ? injPair : lsgPair;
		// optics dark when off; serial steered by loopback
		next_opticEnable = (tmode != fpt_pkg::TM_OFF);
		next_opticSerial = loopback ? 1'b0 : serialRaw;
		next_loopSerial = loopback ? serialRaw : 1'b0;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rfState <= fpt_pkg::RF_PASS;
			inFrame <= 1'b0;
			hold <= fpt_pkg::PAIR_II;
			holdValid <= 1'b0;
			idleCnt <= 4'h0;
			oneArmed <= 1'b0;
			oneOfs <= 8'h00;
			perCnt <= 8'h00;
			txCode <= fpt_pkg::PAIR_QQ;
			opticSerial <= 1'b0;
			opticEnable <= 1'b0;
			loopSerial <= 1'b0;
		end else if (ce) begin
			if (slotReq) begin
				rfState <= next_rfState;
				inFrame <= next_inFrame;
				hold <= next_hold;
				holdValid <= next_holdValid;
				idleCnt <= next_idleCnt;
				oneArmed <= next_oneArmed;
				oneOfs <= next_oneOfs;
				perCnt <= next_perCnt;
				txCode <= next_txCode;
			end
			opticSerial <= next_opticSerial;
			opticEnable <= next_opticEnable;
			loopSerial <= next_loopSerial;
		end
	end

	// the serializer loads the pair registered at the previous slot
	fpt_serializer u_ser (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.pairCode(txCode),
		.nrzSelect(mode_reg[fpt_pkg::MR_NRZ_BIT]),
		.slotReq(slotReq),
		.serialOut(serialRaw)
	);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst || !ce);

	sequence halt_twice_s;
		txCode == fpt_pkg::PAIR_HH ##10 txCode == fpt_pkg::PAIR_HH;
	endsequence

	par_flag_a: assert property (parErr |=>
		interrupt_condition_reg[fpt_pkg::ICR_PARERR_BIT])
		else $error("parity error did not set its flag");
	par_gate_a: assert property (
		$rose(interrupt_condition_reg[fpt_pkg::ICR_PARERR_BIT])
		|-> $past(parEn))
		else $error("parity flag set while checking was off");
	rf_halt_a: assert property (slotReq && rfState == fpt_pkg::RF_PASS
		&& inFrame && viol && !holdValid && tmode == fpt_pkg::TM_ACTIVE
		&& injMode == fpt_pkg::INJ_NONE |=> halt_twice_s)
		else $error("violation not replaced by two halt pairs");
	extend_a: assert property (slotReq && !holdValid
		&& fpt_pkg::is_jk(filtPair) && idleCnt != 4'h0
		&& idleCnt < fpt_pkg::SMOOTH_TARGET && tmode == fpt_pkg::TM_ACTIVE
		&& injMode == fpt_pkg::INJ_NONE
		|=> txCode == fpt_pkg::PAIR_II ##10 fpt_pkg::is_jk(txCode))
		else $error("short preamble was not extended");
	rsvd_quiet_a: assert property (slotReq && tmode[2:1] == 2'h3
		&& injMode == fpt_pkg::INJ_NONE |=> txCode == fpt_pkg::PAIR_QQ)
		else $error("reserved mode did not send quiet");
	lsg_idle_a: assert property (slotReq && tmode == fpt_pkg::TM_IDLE
		&& injMode == fpt_pkg::INJ_NONE |=> txCode == fpt_pkg::PAIR_II)
		else $error("idle mode did not send idle pairs");
	inj_prio_a: assert property (slotReq && injHit
		|=> txCode == $past(injPair))
		else $error("injected pair not sent");
	inj_cont_a: assert property (slotReq
		&& injMode == fpt_pkg::INJ_CONT |-> injHit)
		else $error("continuous mode skipped a pair");
	optic_off_a: assert property (tmode == fpt_pkg::TM_OFF
		|=> !opticEnable)
		else $error("optics enabled in off mode");
	loop_route_a: assert property (loopback |=> !opticSerial
		&& loopSerial == $past(serialRaw))
		else $error("loopback routing wrong");
endmodule : fpt_transmit

/* File: bench/fpt_line_rx.sv */
// line receiver model: undoes the line coding, keeps the last ten bits
`timescale 1ns/10ps
module fpt_line_rx (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// line and coding choice
	input wire logic line,
	input wire logic nrzSelect,
	// last ten decoded bits, newest in bit 0
	output logic [9:0] window
);
	logic prevLevel;

	// line level starts low after reset, so the first one is a rise
	always @(posedge clk) begin
		if (rst) begin
			prevLevel <= 1'b0;
			window <= 10'h000;
		end else begin
			prevLevel <= line;
			window <= {window[8:0], nrzSelect ? line : line ^ prevLevel};
		end
	end
endmodule : fpt_line_rx

/* File: bench/tb_top.sv */
// self-checking bench for the transmit path
`timescale 1ns/10ps
module tb_top;
	typedef struct {int due; logic [9:0] pair;} fpt_exp_t;
	localparam logic [4:0] CODE [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A,
		5'h0B, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C,
		5'h1D};
	localparam logic [9:0] LS [8] = '{fpt_pkg::PAIR_QQ, fpt_pkg::PAIR_II,
		fpt_pkg::PAIR_HQ, fpt_pkg::PAIR_QQ, fpt_pkg::PAIR_HH,
		fpt_pkg::PAIR_QQ, fpt_pkg::PAIR_QQ, fpt_pkg::PAIR_QQ};
	localparam logic [9:0] INJ = {5'h0A, 5'h13};
	localparam logic [9:0] TT = {fpt_pkg::SYM_T, fpt_pkg::SYM_T};
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, hsel = 1'b1, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hready, hreadyout, hresp, txByteValid = 1'b0, txByteReady;
	logic opticSerial, opticEnable, loopSerial, loopMode = 1'b0;
	logic nrzMode = 1'b0;
	logic [9:0] window;
	fpt_pkg::fpt_txbyte_t txByte = '0;
	int errors = 0, n_compared = 0, cyc = 0;
	fpt_exp_t expQ[$];

	// single slave: its ready is the bus ready
	assign hready = hreadyout;

	fpt_transmit dut (.clk, .rst, .ce, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .txByte,
		.txByteValid, .txByteReady, .opticSerial, .opticEnable, .loopSerial);
	fpt_line_rx rx (.clk(clk), .rst(rst),
		.line(loopMode ? loopSerial : opticSerial), .nrzSelect(nrzMode),
		.window(window));

	// 100 MHz clock and an edge count for due times
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;

	task automatic final_report;
		errors += expQ.size(); // pairs that never reached the receiver
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s %0h not %0h", $time, what, got,
				exp);
		end
	endtask : check

	task automatic to_fail(input string what);
		errors++;
		$display("wrong value at %0t: no %s", $time, what);
		final_report;
	endtask : to_fail

	// a pair is fully in the receiver 22 edges after its byte is taken
	always @(posedge clk) begin
		#1;
		if (expQ.size() > 0 && expQ[0].due == cyc) begin
			check(window, expQ[0].pair, "pair");
			void'(expQ.pop_front());
		end
	end

	task automatic wait_ready;
		int i;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (hready !== 1'b1 && i < 50);
		if (i >= 50) to_fail("ready");
	endtask : wait_ready

	// one whole-word transfer; the leading edge leaves an idle cycle
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge clk);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		wait_ready;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready;
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(rd, e, "register");
		check(hresp, 32'h0, "response");
	endtask : rc

	// present a byte, wait for its slot, queue the pair it must become
	task automatic send(input logic v, input logic [9:0] b,
		input logic [9:0] e, input logic c);
		int i;
		txByte <= b;
		txByteValid <= v;
		i = 0;
		do begin
			@(negedge clk);
			i++;
		end while (txByteReady !== 1'b1 && i < 20);
		if (i >= 20) to_fail("slot");
		@(posedge clk);
		// cyc still holds the count before this edge
		if (c) expQ.push_back('{cyc + 23, e});
	endtask : send

	task automatic idle(input int n, input logic c);
		repeat (n) send(1'b0, 10'h000, fpt_pkg::PAIR_II, c);
	endtask : idle

	// odd parity over all ten bits
	function automatic logic [9:0] mk(input logic c, input logic [7:0] d);
		mk = {~^{c, d}, c, d};
	endfunction : mk

	function automatic logic [9:0] dp(input logic [7:0] d);
		dp = {CODE[d[7:4]], CODE[d[3:0]]};
	endfunction : dp

	// main sequence
	initial begin
		int i;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rc(fpt_pkg::ADDR_TSR, 32'h05);
		check(opticEnable, 32'h0, "enable");
		rc(8'h20, 32'h0);
		wr(fpt_pkg::ADDR_ISA, 32'hFFFFFFEA);
		rc(fpt_pkg::ADDR_ISA, 32'h0A);
		wr(fpt_pkg::ADDR_ISB, 32'h13);
		wr(fpt_pkg::ADDR_THR, 32'hFF);
		rc(fpt_pkg::ADDR_THR, 32'hFF);
		wr(fpt_pkg::ADDR_TSR, 32'h0);
		idle(3, 1'b0);
		check(opticEnable, 32'h1, "enable");
		for (i = 0; i < 8; i++) begin
			send(1, mk(0, {i[3:0], ~i[3:0]}), dp({i[3:0], ~i[3:0]}), 1);
		end
		send(1, mk(1, 8'h76), {fpt_pkg::SYM_S, fpt_pkg::SYM_R}, 1);
		send(1, mk(1, 8'h54), TT, 1);
		send(1, mk(0, 8'h12) ^ 10'h200, dp(8'h12), 1);
		idle(3, 1'b1);
		rc(fpt_pkg::ADDR_ICR, 32'h0);
		// parity error inside a frame
		wr(fpt_pkg::ADDR_TSR, 32'h40);
		idle(8, 1'b1);
		send(1, mk(1, 8'hD0), fpt_pkg::PAIR_JK, 1);
		send(1, mk(0, 8'h5A), dp(8'h5A), 1);
		send(1, mk(0, 8'h33) ^ 10'h200, fpt_pkg::PAIR_HH, 1);
		send(1, mk(0, 8'h00), fpt_pkg::PAIR_HH, 1);
		send(1, mk(0, 8'h00), fpt_pkg::PAIR_II, 1);
		idle(3, 1'b0);
		rc(fpt_pkg::ADDR_ICR, 32'h1);
		wr(fpt_pkg::ADDR_ICR, 32'h1);
		rc(fpt_pkg::ADDR_ICR, 32'h0);
		// short preamble gets an extra idle, long one loses it again
		idle(8, 1'b1);
		send(1, mk(1, 8'hD0), fpt_pkg::PAIR_JK, 1);
		send(1, mk(1, 8'h54), TT, 1);
		idle(3, 1'b1);
		send(1, mk(1, 8'hD0), fpt_pkg::PAIR_II, 1);
		send(1, mk(0, 8'h5A), fpt_pkg::PAIR_JK, 1);
		send(1, mk(1, 8'h54), dp(8'h5A), 1);
		idle(1, 1'b0);
		wr(fpt_pkg::ADDR_THR, 32'h2);
		wr(fpt_pkg::ADDR_INJ, 32'h1);
		idle(7, 1'b1);
		send(1, mk(1, 8'hD0), fpt_pkg::PAIR_JK, 1);
		send(1, mk(0, 8'h11), dp(8'h11), 1);
		send(1, mk(0, 8'h22), INJ, 1);
		send(1, mk(0, 8'h44), dp(8'h44), 1);
		idle(3, 1'b0);
		// injection wins over a halt line state
		wr(fpt_pkg::ADDR_INJ, 32'h3);
		wr(fpt_pkg::ADDR_TSR, 32'h44);
		idle(1, 1'b0);
		send(1'b0, 10'h000, INJ, 1'b1);
		wr(fpt_pkg::ADDR_INJ, 32'h2);
		wr(fpt_pkg::ADDR_THR, 32'h0);
		idle(1, 1'b0);
		send(1'b0, 10'h000, INJ, 1'b1);
		// threshold 1: the counter sits at 0, so every second pair is hit
		wr(fpt_pkg::ADDR_THR, 32'h1);
		idle(1, 1'b0);
		send(1'b0, 10'h000, INJ, 1'b1);
		send(1'b0, 10'h000, fpt_pkg::PAIR_HH, 1'b1);
		wr(fpt_pkg::ADDR_INJ, 32'h0);
		for (i = 1; i < 8; i++) begin
			wr(fpt_pkg::ADDR_TSR, i);
			idle(1, 1'b0);
			send(1'b0, 10'h000, LS[i], 1'b1);
			if (i == 5) check(opticEnable, 32'h0, "enable");
		end
		// plain coding on the loopback line
		wr(fpt_pkg::ADDR_TSR, 32'h0);
		wr(fpt_pkg::ADDR_MR, 32'h42);
		loopMode <= 1'b1;
		nrzMode <= 1'b1;
		idle(2, 1'b0);
		send(1, mk(0, 8'hC3), dp(8'hC3), 1);
		idle(3, 1'b0);
		check(opticSerial, 32'h0, "optic line");
		final_report;
	end
endmodule : tb_top
